// File: icsd_params.svh
// icsd_params.svh: offsets, field positions and reset values of the
// interrupt controller enable, status and debug block.
// assumes it is included by every file that needs a constant.
// How it works
// - writing enable_set sets each channel enable whose data bit is one
// - writing enable_clear clears each channel enable whose data bit is one
// - default_vector is 32-bit read-write, reset zero, returned if none active
// - masked_status bit is one only when channel enabled and active
// - status bit n belongs to channel n, channels 0 to 31
// - raw_status shows lines before masking, read-only, reads all ones at reset
// - raw_status reads zero for active channel, one for inactive
// - normal_path_debug bits 11:8 show normal stack pointer, reset zero
// - stack pointer value is the depth, 0 empty up to 8 full
// - both debug words show current_level at 2:0, stack pointer at 11:8, other bits zero
// - fast_path_debug pointer only ever reads 0 or 1
// - channel_enable is 32-bit read-write, reset zero, one enables channel
// - normal stack holds 8 levels; vector read pushes, end write pops
// - while stacked, same or lower priority is masked from the core
// - fast path never nests; at most one fast interrupt in service
`ifndef ICSD_PARAMS_SVH
`define ICSD_PARAMS_SVH
`define ICSD_AW 12
`define ICSD_NCH 32
`define ICSD_DEPTH 8
`define ICSD_RST_WORD 32'h0000_0000
`define ICSD_OFS_EN 12'h000
`define ICSD_OFS_ESET 12'h004
`define ICSD_OFS_ECLR 12'h008
`define ICSD_OFS_DFLT 12'h00c
`define ICSD_OFS_MSTA 12'h010
`define ICSD_OFS_RSTA 12'h014
`define ICSD_OFS_NDBG 12'h018
`define ICSD_OFS_FDBG 12'h01c
`define ICSD_OFS_EVST 12'h030
`define ICSD_OFS_EVMK 12'h034
`define ICSD_OFS_VEC_LO 12'h080
`define ICSD_OFS_VEC_HI 12'h0fc
`define ICSD_OFS_CFG_LO 12'h100
`define ICSD_OFS_CFG_HI 12'h17c
`define ICSD_OFS_NVEC 12'hf00
`define ICSD_OFS_FVEC 12'hf04
`define ICSD_OFS_NEND 12'hf08
`define ICSD_OFS_FEND 12'hf0c
`define ICSD_CH_HI 6
`define ICSD_CH_LO 2
`define ICSD_PTR_HI 11
`define ICSD_PTR_LO 8
`define ICSD_LVL_HI 2
`define ICSD_LVL_LO 0
`define ICSD_CFG_FAST 3
`define ICSD_EVT_OVF 0
`define ICSD_EVT_UNF 1
`define ICSD_EVT_SPUR 2
`endif

// File: icsd_pkg.sv
// icsd_pkg.sv: types shared by the controller and its helpers.
// assumes icsd_params.svh is on the include path.
`include "icsd_params.svh"
package icsd_pkg;
  typedef logic [`ICSD_AW-1:0] icsd_addr_t;
  typedef logic [31:0] icsd_word_t;
  typedef logic [3:0] icsd_ptr_t;
  typedef logic [2:0] icsd_lvl_t;
  typedef logic [3:0] icsd_cfg_t;
  typedef logic [2:0] icsd_evt_t;
  // one bus request, all fields valid in the strobe cycle
  typedef struct packed
  {
    icsd_addr_t addr;
    icsd_word_t wdata;
    logic wr;
    logic rd;
  } icsd_req_s;
  // state of one priority stack as software sees it
  typedef struct packed
  {
    icsd_ptr_t ptr;
    icsd_lvl_t lvl;
  } icsd_stk_s;
endpackage

// File: icsd_mem.sv
// icsd_mem.sv: small single-write, single-read memory, registered read.
// assumes one clock; contents are not reset, only the read register.
`timescale 1ns/1ps
module icsd_mem #(
  parameter int W = 32,
  parameter int D = 32,
  parameter int AW = $clog2(D)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // read port, data one edge after the address
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_q [D];

  // storage; no reset keeps it a plain ram
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  // registered read, old data on a same-address write
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= mem_q[raddr_i];
  end
endmodule

// File: icsd_pick.sv
// icsd_pick.sv: picks the most urgent request among the channels.
// assumes 3-bit priorities, 0 most urgent; purely combinational.
`timescale 1ns/1ps
module icsd_pick #(
  parameter int N = 32,
  parameter int IW = $clog2(N)
) (
  // requests and their priorities, channel i at pri_i[3*i +: 3]
  input wire logic [N-1:0] req_i,
  input wire logic [3*N-1:0] pri_i,
  // winner
  output logic valid_o,
  output logic [IW-1:0] idx_o,
  output logic [2:0] lvl_o
);
  // walking down with <= lets the lower channel win a tie
  always_comb
  begin
    valid_o = 1'b0;
    idx_o = '0;
    lvl_o = '1;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i] && (pri_i[3*i +: 3] <= lvl_o))
      begin
        valid_o = 1'b1;
        idx_o = IW'(i);
        lvl_o = pri_i[3*i +: 3];
      end
    end
  end
endmodule

// File: icsd_ctrl.sv
// icsd_ctrl.sv: vectored interrupt controller core with enable set and
// clear, default vector, status views and priority stack debug words.
// assumes a bus master that never overlaps strobes, sources that are
// synchronous to clk_i and held until cleared at the peripheral.
// a read answer is one word, standing only in the cycle after the strobe.
`timescale 1ns/1ps
`include "icsd_params.svh"
module icsd_ctrl #(
  parameter int NCH = `ICSD_NCH,
  parameter int DEPTH = `ICSD_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register bus
  input icsd_pkg::icsd_req_s req_i,
  output icsd_pkg::icsd_word_t rdata_o,
  // interrupt sources, one per channel, high while active
  input wire logic [NCH-1:0] src_i,
  // lines to the core
  output logic irq_o,
  output logic fiq_o,
  // controller event interrupt
  output logic int_o
);
  import icsd_pkg::*;

  // widths of a channel index and of a stack address
  localparam int CW = $clog2(NCH);
  localparam int SW = $clog2(DEPTH);

  // true when a is word aligned inside [lo, hi]
  function automatic logic in_range(input icsd_addr_t a,
                                    input icsd_addr_t lo,
                                    input icsd_addr_t hi);
    in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
  endfunction

  // channel number carried by a per-channel register address
  function automatic logic [CW-1:0] chan_of(input icsd_addr_t a);
    chan_of = CW'(a[`ICSD_CH_HI:`ICSD_CH_LO]);
  endfunction

  // debug word layout, shared by both paths
  function automatic icsd_word_t dbg_word(input icsd_stk_s s);
    dbg_word = `ICSD_RST_WORD;
    dbg_word[`ICSD_PTR_HI:`ICSD_PTR_LO] = s.ptr;
    dbg_word[`ICSD_LVL_HI:`ICSD_LVL_LO] = s.lvl;
  endfunction

  // registers: enables and default vector
  logic [NCH-1:0] en_ff;
  logic [NCH-1:0] nxt_en;
  icsd_word_t dflt_ff;
  icsd_word_t nxt_dflt;
  // channel configuration and event status
  icsd_cfg_t cfg_ff [NCH];
  icsd_evt_t evst_ff;
  icsd_evt_t nxt_evst;
  icsd_evt_t evmk_ff;
  icsd_evt_t nxt_evmk;
  // stack state of both paths
  icsd_ptr_t nptr_ff;
  icsd_ptr_t nxt_nptr;
  icsd_lvl_t nlvl_ff;
  icsd_lvl_t nxt_nlvl;
  logic fbusy_ff;
  logic nxt_fbusy;
  icsd_lvl_t flvl_ff;
  icsd_lvl_t nxt_flvl;
  // read path and core lines
  icsd_word_t rdata_ff;
  icsd_word_t nxt_rdata;
  logic vsel_ff;
  logic nxt_vsel;
  logic irq_ff;
  logic fiq_ff;
  logic int_ff;

  // address decode
  wire logic wr = req_i.wr;
  wire logic rd = req_i.rd;
  wire icsd_addr_t addr = req_i.addr;
  wire icsd_word_t wdata = req_i.wdata;
  wire logic hit_en = (addr == `ICSD_OFS_EN);
  wire logic hit_eset = (addr == `ICSD_OFS_ESET);
  wire logic hit_eclr = (addr == `ICSD_OFS_ECLR);
  wire logic hit_dflt = (addr == `ICSD_OFS_DFLT);
  wire logic hit_msta = (addr == `ICSD_OFS_MSTA);
  wire logic hit_rsta = (addr == `ICSD_OFS_RSTA);
  wire logic hit_ndbg = (addr == `ICSD_OFS_NDBG);
  wire logic hit_fdbg = (addr == `ICSD_OFS_FDBG);
  wire logic hit_evst = (addr == `ICSD_OFS_EVST);
  wire logic hit_evmk = (addr == `ICSD_OFS_EVMK);
  wire logic hit_nvec = (addr == `ICSD_OFS_NVEC);
  wire logic hit_fvec = (addr == `ICSD_OFS_FVEC);
  wire logic hit_nend = (addr == `ICSD_OFS_NEND);
  wire logic hit_fend = (addr == `ICSD_OFS_FEND);
  // per-channel windows, one word for each channel
  wire logic hit_vec = in_range(addr, `ICSD_OFS_VEC_LO, `ICSD_OFS_VEC_HI);
  wire logic hit_cfg = in_range(addr, `ICSD_OFS_CFG_LO, `ICSD_OFS_CFG_HI);
  wire logic [CW-1:0] ch = chan_of(addr);

  // status views: live, so a source cleared at the peripheral drops here
  // in the same cycle
  wire logic [NCH-1:0] mstat = src_i & en_ff;
  wire logic [NCH-1:0] rstat = ~src_i;

  // per-channel type, priority and eligibility
  logic [NCH-1:0] is_fast;
  logic [3*NCH-1:0] pri_flat;
  logic [NCH-1:0] n_elig;
  logic [NCH-1:0] f_elig;
  wire logic n_empty = (nptr_ff == '0);
  wire logic n_full = (nptr_ff == icsd_ptr_t'(DEPTH));
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    wire icsd_lvl_t pri = cfg_ff[i][`ICSD_LVL_HI:`ICSD_LVL_LO];
    assign is_fast[i] = cfg_ff[i][`ICSD_CFG_FAST];
    assign pri_flat[3*i +: 3] = pri;
    // stacked level blocks same and lower priority, 0 is most urgent
    assign n_elig[i] = mstat[i] & ~is_fast[i] &
                       (n_empty | (pri < nlvl_ff));
    // fast channels ignore the stacked normal level
    assign f_elig[i] = mstat[i] & is_fast[i];
  end

  // arbitration for each path
  logic n_valid;
  logic [CW-1:0] n_idx;
  icsd_lvl_t n_lvl;
  logic f_valid;
  logic [CW-1:0] f_idx;
  icsd_lvl_t f_lvl;
  // normal path winner among eligible channels
  icsd_pick #(.N(NCH)) u_npick (
    .req_i(n_elig),
    .pri_i(pri_flat),
    .valid_o(n_valid),
    .idx_o(n_idx),
    .lvl_o(n_lvl)
  );
  // fast path winner, never masked by the stack
  icsd_pick #(.N(NCH)) u_fpick (
    .req_i(f_elig),
    .pri_i(pri_flat),
    .valid_o(f_valid),
    .idx_o(f_idx),
    .lvl_o(f_lvl)
  );

  // stack operations and controller events
  wire logic rd_nvec = rd & hit_nvec;
  wire logic rd_fvec = rd & hit_fvec;
  wire logic wr_nend = wr & hit_nend;
  wire logic wr_fend = wr & hit_fend;
  // a refused push still answers with the vector
  wire logic n_push = rd_nvec & n_valid & ~n_full;
  wire logic n_pop = wr_nend & ~n_empty;
  wire logic f_push = rd_fvec & f_valid & ~fbusy_ff;
  wire logic f_pop = wr_fend & fbusy_ff;
  // controller events for the status word
  wire logic ev_ovf = (rd_nvec & n_valid & n_full) |
                      (rd_fvec & f_valid & fbusy_ff);
  wire logic ev_unf = (wr_nend & n_empty) | (wr_fend & ~fbusy_ff);
  wire logic ev_spur = (rd_nvec & ~n_valid) | (rd_fvec & ~f_valid);
  icsd_evt_t ev_now;
  // pack the events at their field positions
  always_comb
  begin
    ev_now = '0;
    ev_now[`ICSD_EVT_OVF] = ev_ovf;
    ev_now[`ICSD_EVT_UNF] = ev_unf;
    ev_now[`ICSD_EVT_SPUR] = ev_spur;
  end

  // stack of stacked levels; the read side always shows the entry under
  // the top, so a pop finds the level to fall back to without a wait
  icsd_lvl_t stk_under;
  wire logic [SW-1:0] stk_waddr = SW'(nptr_ff);
  wire logic [SW-1:0] stk_raddr = SW'(nxt_nptr - icsd_ptr_t'(2));
  icsd_mem #(.W(3), .D(DEPTH)) u_stack (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(n_push),
    .waddr_i(stk_waddr),
    .wdata_i(n_lvl),
    .raddr_i(stk_raddr),
    .rdata_o(stk_under)
  );

  // stack pointer counts entries directly, capped at DEPTH
  assign nxt_nptr = n_push ? nptr_ff + icsd_ptr_t'(1) :
                    n_pop ? nptr_ff - icsd_ptr_t'(1) :
                    nptr_ff;
  // a pop falls back to the entry under the top, zero when empty
  assign nxt_nlvl = n_push ? n_lvl :
                    !n_pop ? nlvl_ff :
                    (nptr_ff >= icsd_ptr_t'(2)) ? stk_under :
                    icsd_lvl_t'(0);
  // fast path holds one entry only, so a flag is enough
  assign nxt_fbusy = f_push | (fbusy_ff & ~f_pop);
  assign nxt_flvl = f_push ? f_lvl :
                    f_pop ? icsd_lvl_t'(0) :
                    flvl_ff;

  // vector table, written per channel, read for the winning channel
  icsd_word_t vec_q;
  wire logic [CW-1:0] vec_raddr = rd_fvec ? f_idx : n_idx;
  icsd_mem #(.W(32), .D(NCH)) u_vec (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(wr & hit_vec),
    .waddr_i(ch),
    .wdata_i(wdata),
    .raddr_i(vec_raddr),
    .rdata_o(vec_q)
  );

  // enables: direct write, or set and clear by one bits only
  assign nxt_en = (wr & hit_en) ? wdata[NCH-1:0] :
                  (wr & hit_eset) ? (en_ff | wdata[NCH-1:0]) :
                  (wr & hit_eclr) ? (en_ff & ~wdata[NCH-1:0]) :
                  en_ff;
  assign nxt_dflt = (wr & hit_dflt) ? wdata : dflt_ff;
  // write-one clear mask, zero unless the status word is written
  wire icsd_evt_t ev_clr = (wr & hit_evst) ?
                           wdata[$bits(icsd_evt_t)-1:0] :
                           icsd_evt_t'(0);
  // a new event beats a write-one clear in the same cycle
  assign nxt_evst = (evst_ff & ~ev_clr) | ev_now;
  assign nxt_evmk = (wr & hit_evmk) ?
                    wdata[$bits(icsd_evt_t)-1:0] : evmk_ff;

  // debug views of both stacks
  icsd_stk_s n_dbg;
  icsd_stk_s f_dbg;
  assign n_dbg.ptr = nptr_ff;
  assign n_dbg.lvl = nlvl_ff;
  assign f_dbg.ptr = icsd_ptr_t'(fbusy_ff);
  assign f_dbg.lvl = flvl_ff;

  // read selection; unmapped and write-only addresses read zero, and a
  // vector read with nothing pending returns the default vector
  wire icsd_word_t cfg_word = icsd_word_t'(cfg_ff[ch]);
  assign nxt_rdata = !rd ? `ICSD_RST_WORD :
                     hit_en ? icsd_word_t'(en_ff) :
                     hit_dflt ? dflt_ff :
                     hit_msta ? icsd_word_t'(mstat) :
                     hit_rsta ? icsd_word_t'(rstat) :
                     hit_ndbg ? dbg_word(n_dbg) :
                     hit_fdbg ? dbg_word(f_dbg) :
                     hit_evst ? icsd_word_t'(evst_ff) :
                     hit_evmk ? icsd_word_t'(evmk_ff) :
                     hit_cfg ? cfg_word :
                     (hit_nvec | hit_fvec) ? dflt_ff :
                     `ICSD_RST_WORD;
  // the table answers only when a winner existed at the read edge
  assign nxt_vsel = (rd_nvec & n_valid) | (rd_fvec & f_valid);
  // vector data come from the table's own read register, saving a
  // second 32-bit stage at the price of one mux after the flops
  assign rdata_o = vsel_ff ? vec_q : rdata_ff;

  // enable, default vector and event registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_ff <= '0;
      dflt_ff <= `ICSD_RST_WORD;
      evst_ff <= '0;
      evmk_ff <= '0;
    end
    else
    begin
      en_ff <= nxt_en;
      dflt_ff <= nxt_dflt;
      evst_ff <= nxt_evst;
      evmk_ff <= nxt_evmk;
    end
  end

  // per-channel configuration, type bit and priority
  // kept in flops, since every channel's priority is needed at once
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NCH; i++)
        cfg_ff[i] <= '0;
    end
    else if (wr && hit_cfg)
    begin
      cfg_ff[ch] <= wdata[3:0];
    end
  end

  // priority stack state of both paths
  // levels below the top stay in u_stack, only the top is here
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nptr_ff <= '0;
      nlvl_ff <= '0;
      fbusy_ff <= 1'b0;
      flvl_ff <= '0;
    end
    else
    begin
      nptr_ff <= nxt_nptr;
      nlvl_ff <= nxt_nlvl;
      fbusy_ff <= nxt_fbusy;
      flvl_ff <= nxt_flvl;
    end
  end

  // read data and output lines
  // rdata_ff falls back to zero the cycle after a read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= `ICSD_RST_WORD;
      vsel_ff <= 1'b0;
      irq_ff <= 1'b0;
      fiq_ff <= 1'b0;
      int_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      vsel_ff <= nxt_vsel;
      irq_ff <= n_valid;
      fiq_ff <= f_valid & ~fbusy_ff;
      int_ff <= |(evst_ff & evmk_ff);
    end
  end

  // core lines come straight from their flops
  assign irq_o = irq_ff;
  assign fiq_o = fiq_ff;
  assign int_o = int_ff;
endmodule

// File: icsd_ctrl_assertions.sv
// icsd_ctrl_assertions.sv: port-level checks of the enable, status
// and debug views, bound into every icsd_ctrl.
// assumes the one-cycle read answer and registered core lines.
`timescale 1ns/1ps
`include "icsd_params.svh"
module icsd_ctrl_chk #(
  parameter int NCH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input icsd_pkg::icsd_req_s req_i,
  input icsd_pkg::icsd_word_t rdata_o,
  input wire logic [NCH-1:0] src_i,
  input wire logic irq_o,
  input wire logic fiq_o,
  input wire logic int_o
);
  import icsd_pkg::*;
  icsd_word_t en_ff;
  icsd_word_t dv_ff;
  icsd_word_t nxt_en;
  icsd_word_t nxt_dv;
  // address decode of the watched requests
  wire logic wr_en = req_i.wr && req_i.addr == `ICSD_OFS_EN;
  wire logic wr_set = req_i.wr && req_i.addr == `ICSD_OFS_ESET;
  wire logic wr_clr = req_i.wr && req_i.addr == `ICSD_OFS_ECLR;
  wire logic wr_dv = req_i.wr && req_i.addr == `ICSD_OFS_DFLT;
  wire logic rd_en = req_i.rd && req_i.addr == `ICSD_OFS_EN;
  wire logic rd_dv = req_i.rd && req_i.addr == `ICSD_OFS_DFLT;
  wire logic rd_ms = req_i.rd && req_i.addr == `ICSD_OFS_MSTA;
  wire logic rd_rs = req_i.rd && req_i.addr == `ICSD_OFS_RSTA;
  wire logic rd_nd = req_i.rd && req_i.addr == `ICSD_OFS_NDBG;
  wire logic rd_fd = req_i.rd && req_i.addr == `ICSD_OFS_FDBG;
  wire logic rd_nv = req_i.rd && req_i.addr == `ICSD_OFS_NVEC;
  wire logic rd_fv = req_i.rd && req_i.addr == `ICSD_OFS_FVEC;
  wire logic pend = |(src_i & en_ff[NCH-1:0]);
  // shadow enables: set and clear touch only the one bits
  assign nxt_en = wr_en ? req_i.wdata : wr_set ? en_ff | req_i.wdata :
    wr_clr ? en_ff & ~req_i.wdata : en_ff;
  assign nxt_dv = wr_dv ? req_i.wdata : dv_ff;
  // shadow registers, cleared with the design
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_ff <= 32'h0;
      dv_ff <= 32'h0;
    end
    else
    begin
      en_ff <= nxt_en;
      dv_ff <= nxt_dv;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_mask_view: assert property (rd_ms |=>
    rdata_o == $past(src_i & en_ff[NCH-1:0]))
    else $error("masked status differs from lines and enables");
  chk_raw_inverse: assert property (rd_rs |=>
    rdata_o == ~$past(src_i))
    else $error("raw status not the inverse of the lines");
  chk_enable_read: assert property (rd_en |=>
    rdata_o == $past(en_ff))
    else $error("enable read differs from written enables");
  chk_dflt_read: assert property (rd_dv |=>
    rdata_o == $past(dv_ff))
    else $error("default vector read wrong");
  chk_dflt_spurious: assert property ((rd_nv || rd_fv) && !pend |=>
    rdata_o == $past(dv_ff))
    else $error("vector port did not give default vector");
  chk_dbg_reserved: assert property ((rd_nd || rd_fd) |=>
    rdata_o[31:12] == 20'h0 && rdata_o[7:3] == 5'h0)
    else $error("debug word reserved bits not zero");
  chk_fast_ptr: assert property (rd_fd |=>
    rdata_o[11:8] <= 4'h1)
    else $error("fast stack pointer above one");
  chk_norm_ptr: assert property (rd_nd |=>
    rdata_o[11:8] <= DEPTH)
    else $error("normal stack pointer above depth");
  chk_irq_cause: assert property (irq_o |-> $past(pend))
    else $error("normal line high with no enabled active source");
  chk_fiq_cause: assert property ($rose(fiq_o) |-> $past(pend))
    else $error("fast line rose with no enabled active source");
  chk_evt_cause: assert property ($rose(int_o) |->
    $past(req_i.rd || req_i.wr, 2))
    else $error("event line rose with no request two cycles before");
endmodule

bind icsd_ctrl icsd_ctrl_chk #(.NCH(NCH), .DEPTH(DEPTH)) u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .src_i(src_i),
  .irq_o(irq_o),
  .fiq_o(fiq_o),
  .int_o(int_o)
);

// File: icsd_src_model.sv
// icsd_src_model.sv: peripheral interrupt sources on the far side.
// assumes the bench pulses set and clear masks for one cycle.
`timescale 1ns/1ps
module icsd_src_model #(
  parameter int NCH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bench control, one bit per channel
  input wire logic [NCH-1:0] set_i,
  input wire logic [NCH-1:0] clr_i,
  // level lines into the controller
  output logic [NCH-1:0] src_o
);
  logic [NCH-1:0] lvl_ff;
  logic [NCH-1:0] nxt_lvl;
  // latched here, since the controller itself never latches
  assign nxt_lvl = (lvl_ff & ~clr_i) | set_i;
  assign src_o = lvl_ff;
  // request held until the handler clears it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lvl_ff <= '0;
    else
      lvl_ff <= nxt_lvl;
  end
endmodule

// File: tb_top.sv
// tb_top.sv: self-checking bench of the controller register views.
// assumes the source model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "icsd_params.svh"
module tb_top;
  import icsd_pkg::*;
  logic clk_i;
  logic rst_n_i;
  icsd_req_s req;
  icsd_word_t rdata;
  icsd_word_t s_set;
  icsd_word_t s_clr;
  icsd_word_t src;
  logic irq;
  logic fiq;
  logic evt;
  int n_mismatch;
  int samples_checked;
  icsd_addr_t ra[6] = '{`ICSD_OFS_EN, `ICSD_OFS_DFLT, `ICSD_OFS_MSTA,
    `ICSD_OFS_RSTA, `ICSD_OFS_NDBG, `ICSD_OFS_FDBG};
  icsd_word_t rv[6] = '{32'h0, 32'h0, 32'h0, 32'hffff_ffff, 32'h0, 32'h0};
  icsd_ctrl dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req),
    .rdata_o(rdata),
    .src_i(src),
    .irq_o(irq),
    .fiq_o(fiq),
    .int_o(evt)
  );
  icsd_src_model u_src (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(s_set),
    .clr_i(s_clr),
    .src_o(src)
  );
  // 10 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input icsd_word_t got, input icsd_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, released at the edge that takes them
  task automatic wr(input icsd_addr_t a, input icsd_word_t d);
    @(posedge clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rc(input icsd_addr_t a, input icsd_word_t e);
    @(posedge clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  task automatic src_ctl(input icsd_word_t s, input icsd_word_t c);
    @(posedge clk_i);
    s_set <= s;
    s_clr <= c;
    @(posedge clk_i);
    s_set <= 32'h0;
    s_clr <= 32'h0;
  endtask
  // lines are registered, so allow a few cycles to settle
  task automatic lines(input logic [2:0] e);
    logic [2:0] got;
    got = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      #1;
      got = {evt, fiq, irq};
      if (got === e)
        break;
    end
    cmp({29'h0, got}, {29'h0, e});
    if (got !== e)
      close_out();
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    req = 46'h0;
    s_set = 32'h0;
    s_clr = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++)
      rc(ra[i], rv[i]);
    rc(12'h200, 32'h0);
    wr(`ICSD_OFS_ESET, 32'h0000_00a5);
    wr(`ICSD_OFS_ESET, 32'h8000_0001);
    rc(`ICSD_OFS_EN, 32'h8000_00a5);
    wr(`ICSD_OFS_ECLR, 32'h0000_0081);
    rc(`ICSD_OFS_EN, 32'h8000_0024);
    wr(`ICSD_OFS_MSTA, 32'hffff_ffff);
    rc(`ICSD_OFS_MSTA, 32'h0);
    src_ctl(32'h8000_0030, 32'h0);
    rc(`ICSD_OFS_MSTA, 32'h8000_0020);
    rc(`ICSD_OFS_RSTA, 32'h7fff_ffcf);
    lines(3'b001);
    src_ctl(32'h0, 32'h8000_0000);
    rc(`ICSD_OFS_MSTA, 32'h0000_0020);
    wr(`ICSD_OFS_ECLR, 32'h0000_0020);
    rc(`ICSD_OFS_MSTA, 32'h0);
    lines(3'b000);
    // spurious reads give the default vector and raise an event
    wr(`ICSD_OFS_DFLT, 32'h0000_1f00);
    rc(`ICSD_OFS_DFLT, 32'h0000_1f00);
    rc(`ICSD_OFS_NVEC, 32'h0000_1f00);
    rc(`ICSD_OFS_NDBG, 32'h0);
    rc(`ICSD_OFS_EVST, 32'h4);
    lines(3'b000);
    wr(`ICSD_OFS_EVMK, 32'h7);
    lines(3'b100);
    wr(`ICSD_OFS_EVST, 32'h4);
    lines(3'b000);
    rc(`ICSD_OFS_FVEC, 32'h0000_1f00);
    lines(3'b100);
    wr(`ICSD_OFS_EVST, 32'h4);
    // channels 8..15 at priorities 7..0 fill the normal stack
    for (int k = 0; k < 8; k++)
    begin
      wr(`ICSD_OFS_CFG_LO + 12'(32 + 4 * k), icsd_word_t'(7 - k));
      wr(`ICSD_OFS_VEC_LO + 12'(32 + 4 * k), icsd_word_t'(512 + k));
    end
    wr(`ICSD_OFS_ESET, 32'h0000_ff00);
    for (int k = 0; k < 8; k++)
    begin
      src_ctl(icsd_word_t'(256) << k, 32'h0);
      lines(3'b001);
      rc(`ICSD_OFS_NVEC, icsd_word_t'(512 + k));
      rc(`ICSD_OFS_NDBG, icsd_word_t'((k + 1) * 256 + 7 - k));
      lines(3'b000);
    end
    for (int k = 7; k >= 0; k--)
    begin
      wr(`ICSD_OFS_NEND, 32'h0);
      lines(3'b001);
      rc(`ICSD_OFS_NDBG, icsd_word_t'(k * 256 + (k > 0 ? 8 - k : 0)));
    end
    wr(`ICSD_OFS_NEND, 32'h0);
    lines(3'b101);
    rc(`ICSD_OFS_EVST, 32'h2);
    wr(`ICSD_OFS_EVST, 32'h2);
    src_ctl(32'h0, 32'h0000_ff00);
    lines(3'b000);
    // two fast channels at one priority; the fast path never nests
    wr(`ICSD_OFS_CFG_LO + 12'h004, 32'h8);
    wr(`ICSD_OFS_CFG_LO + 12'h00c, 32'h8);
    wr(`ICSD_OFS_VEC_LO + 12'h004, 32'h301);
    wr(`ICSD_OFS_VEC_LO + 12'h00c, 32'h300);
    wr(`ICSD_OFS_ESET, 32'h0000_000a);
    src_ctl(32'h8, 32'h0);
    lines(3'b010);
    rc(`ICSD_OFS_FVEC, 32'h300);
    rc(`ICSD_OFS_FDBG, 32'h100);
    rc(`ICSD_OFS_FVEC, 32'h300);
    rc(`ICSD_OFS_FDBG, 32'h100);
    rc(`ICSD_OFS_EVST, 32'h1);
    wr(`ICSD_OFS_EVST, 32'h1);
    lines(3'b000);
    src_ctl(32'h2, 32'h0);
    lines(3'b000);
    rc(`ICSD_OFS_FDBG, 32'h100);
    wr(`ICSD_OFS_FEND, 32'h0);
    rc(`ICSD_OFS_FDBG, 32'h0);
    lines(3'b010);
    rc(`ICSD_OFS_FVEC, 32'h301);
    wr(`ICSD_OFS_FEND, 32'h0);
    wr(`ICSD_OFS_FEND, 32'h0);
    rc(`ICSD_OFS_EVST, 32'h2);
    wr(`ICSD_OFS_EVST, 32'h2);
    src_ctl(32'h0, 32'h0000_000a);
    lines(3'b000);
    wr(`ICSD_OFS_EN, 32'h5a5a_0f0f);
    rc(`ICSD_OFS_EN, 32'h5a5a_0f0f);
    rc(`ICSD_OFS_CFG_LO + 12'h004, 32'h8);
    rc(`ICSD_OFS_VEC_LO + 12'h004, 32'h0);
    // second reset in mid-run
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc(`ICSD_OFS_EN, 32'h0);
    rc(`ICSD_OFS_DFLT, 32'h0);
    close_out();
  end
  // watchdog against a hung run
  initial
  begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule
